// ---- wdp_consts.svh ----
`ifndef WDP_CONSTS_SVH
`define WDP_CONSTS_SVH

// Register byte offsets
`define WDP_ADDR_CTRL0 8'h00
`define WDP_ADDR_CTRL1 8'h04
`define WDP_ADDR_STAT 8'h08
`define WDP_ADDR_CNT 8'h0c
`define WDP_ADDR_IRQ 8'h10
`define WDP_ADDR_MASK 8'h14
`define WDP_ADDR_W 8

// Control word 0 fields
`define WDP_C0_LOCK 0
`define WDP_C0_GUARD 7:4
`define WDP_C0_PW 15:8
`define WDP_C0_RELOAD 31:16

// Control word 1 fields
`define WDP_C1_DIS 0
`define WDP_C1_FSEL 1
`define WDP_C1_UPW 7:4

// Password and guard values
`define WDP_FIXED_PW 4'h5
`define WDP_GUARD_VAL 4'ha

// Reset and fixed reload values
`define WDP_RELOAD_RST 16'h0000
`define WDP_UPW_RST 4'h0
`define WDP_TIMEOUT_RELOAD 16'h0000
`define WDP_PREWARN_RELOAD 16'hff00
`define WDP_CNT_MAX 16'hffff

// Prescaler masks for clk/256 and clk/16384
`define WDP_DIV_FAST 14'h00ff
`define WDP_DIV_SLOW 14'h3fff

// Interrupt status bits
`define WDP_IRQ_W 3
`define WDP_IRQ_SVC 0
`define WDP_IRQ_LOCK 1
`define WDP_IRQ_WIN 2

// Timing
`define WDP_CLK_MHZ 250
`define WDP_WIN_NS 1024
`define WDP_WIN_CYC ((`WDP_WIN_NS * `WDP_CLK_MHZ) / 1000)
`define WDP_RST_NS 64
`define WDP_RST_CYC ((`WDP_RST_NS * `WDP_CLK_MHZ) / 1000)

`endif

// ---- wdp_pkg.sv ----
package wdp_pkg;

   // Supervision states, one-hot
   typedef enum logic [4:0] {
      WDP_ST_TIMEOUT = 5'h01,
      WDP_ST_NORMAL = 5'h02,
      WDP_ST_PREWARN = 5'h04,
      WDP_ST_RESET = 5'h08,
      WDP_ST_HALT = 5'h10
   } wdp_state_t;

   // Software configuration held in control word 1
   typedef struct packed {
      logic [3:0] user_pw;
      logic slow_sel;
      logic cnt_dis;
   } wdp_cfg_t;

endpackage : wdp_pkg

// ---- wdp_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdp_consts.svh"

module wdp_tick_div (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_slow,
   output logic o_tick
);

   logic [13:0] div_cnt;
   wire [13:0] div_mask = i_slow ? `WDP_DIV_SLOW : `WDP_DIV_FAST;

   // Free-running divider; one-cycle enable each 256 or 16384 clocks
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         div_cnt <= 14'h0000;
         o_tick <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 14'h0001;
         o_tick <= ((div_cnt & div_mask) == div_mask);
      end
   end

endmodule : wdp_tick_div
`default_nettype wire

// ---- wdp_top.sv ----
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdp_consts.svh"

// What this block does
// - 16-bit counter ticks at clock/256 or clock/16384, software selects.
// - Normal mode reloads software value; time-out and prewarning use fixed reloads.
// - While enabled, missing service leads to a system reset.
// - Errors first raise a non-maskable interrupt, reset follows a period later.
// - Init-done lock bit is driven out system-wide; every change made by a service write is flagged.
// - Control word 0 writes need a password of fixed and software-defined parts.
// - Gap between the two writes is timed; too long voids the sequence.
// - Bad password on first write or bad guard on second starts reset.
// - With counting disabled, password and lock monitoring stay active.
// - Two timer resets without valid access between hold reset until power-on.
module wdp_top (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_init_done_lock,
   output logic o_nmi,
   output logic o_wd_reset,
   output logic o_irq
);

   // Bus data phase bookkeeping
   logic pend;
   logic pend_wr;
   logic [`WDP_ADDR_W-1:0] pend_addr;

   // Supervision state
   wdp_pkg::wdp_state_t state;
   wdp_pkg::wdp_state_t next_state;
   wdp_pkg::wdp_cfg_t cfg;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [15:0] reload;
   logic lock;
   logic win_open;
   logic [8:0] win_cnt;
   logic [7:0] rst_cnt;
   logic reset_seen;
   logic err_acc;
   logic err_ovf;
   logic [`WDP_IRQ_W-1:0] irq_st;
   logic [`WDP_IRQ_W-1:0] irq_mask;
   logic [`WDP_IRQ_W-1:0] next_irq_st;
   logic tick;

   // Size is ignored: only whole-word single transfers are expected
   wire unused_size = ^i_hsize;

   // Address phase accepted only when the bus is ready
   wire bus_take = i_hsel & i_htrans[1] & i_hready;
   wire wr_now = pend & pend_wr;
   wire rd_now = pend & ~pend_wr;
   wire wr_c0 = wr_now & (pend_addr == `WDP_ADDR_CTRL0);
   wire wr_c1 = wr_now & (pend_addr == `WDP_ADDR_CTRL1);
   wire wr_irq = wr_now & (pend_addr == `WDP_ADDR_IRQ);
   wire wr_mask = wr_now & (pend_addr == `WDP_ADDR_MASK);

   // States in which the protected access engine is frozen
   wire blocked = (state == wdp_pkg::WDP_ST_PREWARN) | (state == wdp_pkg::WDP_ST_RESET)
      | (state == wdp_pkg::WDP_ST_HALT);

   // Password check, guard check and window timing
   wire [7:0] pw_exp = {`WDP_FIXED_PW, cfg.user_pw};
   wire pw_match = (i_hwdata[`WDP_C0_PW] == pw_exp);
   wire guard_match = (i_hwdata[`WDP_C0_GUARD] == `WDP_GUARD_VAL);
   wire first_ok = wr_c0 & ~blocked & ~win_open & pw_match;
   wire first_bad = wr_c0 & ~blocked & ~win_open & ~pw_match;
   wire second_ok = wr_c0 & ~blocked & win_open & guard_match;
   wire second_bad = wr_c0 & ~blocked & win_open & ~guard_match;
   // Last count is one short so a write 1024 ns after opening is the last accepted
   wire win_exp = win_open & ~wr_c0 & (win_cnt == 9'(`WDP_WIN_CYC - 1));
   wire acc_err = first_bad | second_bad;
   wire new_lock = i_hwdata[`WDP_C0_LOCK];
   wire lock_change = second_ok & (new_lock != lock);

   // Counting stays off in normal mode only when software disables it
   wire cnt_run = (state == wdp_pkg::WDP_ST_TIMEOUT) | (state == wdp_pkg::WDP_ST_PREWARN)
      | ((state == wdp_pkg::WDP_ST_NORMAL) & ~cfg.cnt_dis);
   wire count_en = tick & cnt_run;
   wire ovf = count_en & (cnt == `WDP_CNT_MAX);
   wire run_err = acc_err | ovf;
   wire rst_done = (rst_cnt == 8'(`WDP_RST_CYC - 1));

   // Prescaler enable
   wdp_tick_div u_div (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_slow(cfg.slow_sel),
      .o_tick(tick)
   );

   // Next state of the supervision sequence
   always_comb begin
      next_state = state;
      unique case (state)
         wdp_pkg::WDP_ST_TIMEOUT: begin
            if (run_err) begin
               next_state = wdp_pkg::WDP_ST_PREWARN;
            end else if (second_ok & new_lock) begin
               next_state = wdp_pkg::WDP_ST_NORMAL;
            end
         end
         wdp_pkg::WDP_ST_NORMAL: begin
            if (run_err) begin
               next_state = wdp_pkg::WDP_ST_PREWARN;
            end else if (second_ok & ~new_lock) begin
               next_state = wdp_pkg::WDP_ST_TIMEOUT;
            end
         end
         wdp_pkg::WDP_ST_PREWARN: begin
            if (ovf) begin
               next_state = reset_seen ? wdp_pkg::WDP_ST_HALT : wdp_pkg::WDP_ST_RESET;
            end
         end
         wdp_pkg::WDP_ST_RESET: begin
            if (rst_done) begin
               next_state = wdp_pkg::WDP_ST_TIMEOUT;
            end
         end
         wdp_pkg::WDP_ST_HALT: begin
            next_state = wdp_pkg::WDP_ST_HALT;
         end
         default: begin
            next_state = wdp_pkg::WDP_ST_TIMEOUT;
         end
      endcase
   end

   // Counter reload selection; fixed values outside normal mode
   always_comb begin
      next_cnt = cnt;
      if (next_state == wdp_pkg::WDP_ST_PREWARN && state != wdp_pkg::WDP_ST_PREWARN) begin
         next_cnt = `WDP_PREWARN_RELOAD;
      end else if (state == wdp_pkg::WDP_ST_RESET) begin
         next_cnt = `WDP_TIMEOUT_RELOAD;
      end else if (second_ok) begin
         next_cnt = new_lock ? i_hwdata[`WDP_C0_RELOAD] : `WDP_TIMEOUT_RELOAD;
      end else if (count_en) begin
         next_cnt = cnt + 16'h0001;
      end
   end

   // Sticky interrupt bits; a new event beats a same-cycle clear
   always_comb begin
      next_irq_st = irq_st;
      if (wr_irq) begin
         next_irq_st = irq_st & ~i_hwdata[`WDP_IRQ_W-1:0];
      end
      next_irq_st[`WDP_IRQ_SVC] = next_irq_st[`WDP_IRQ_SVC] | second_ok;
      next_irq_st[`WDP_IRQ_LOCK] = next_irq_st[`WDP_IRQ_LOCK] | lock_change;
      next_irq_st[`WDP_IRQ_WIN] = next_irq_st[`WDP_IRQ_WIN] | win_exp;
   end

   // Bus phase tracking; one wait state so read data come from a flop
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pend <= 1'b0;
         pend_wr <= 1'b0;
         pend_addr <= `WDP_ADDR_CTRL0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         pend <= bus_take;
         o_hreadyout <= ~bus_take;
         o_hresp <= 1'b0;
         if (bus_take) begin
            pend_wr <= i_hwrite;
            pend_addr <= i_haddr[`WDP_ADDR_W-1:0];
         end
      end
   end

   // Read data; unmapped offsets read zero
   wire [31:0] rd_c0 = {reload, 8'h00, 4'h0, 2'b00, win_open, lock};
   wire [31:0] rd_c1 = {24'h000000, cfg.user_pw, 2'b00, cfg.slow_sel, cfg.cnt_dis};
   wire [31:0] rd_st = {22'h000000, err_ovf, err_acc, state, reset_seen, lock, win_open};
   wire [31:0] rd_mux =
      (pend_addr == `WDP_ADDR_CTRL0) ? rd_c0 :
      (pend_addr == `WDP_ADDR_CTRL1) ? rd_c1 :
      (pend_addr == `WDP_ADDR_STAT) ? rd_st :
      (pend_addr == `WDP_ADDR_CNT) ? {16'h0000, cnt} :
      (pend_addr == `WDP_ADDR_IRQ) ? {29'h00000000, irq_st} :
      (pend_addr == `WDP_ADDR_MASK) ? {29'h00000000, irq_mask} : 32'h00000000;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_hrdata <= 32'h00000000;
      end else if (rd_now) begin
         o_hrdata <= rd_mux;
      end
   end

   // Two-write access window and its timer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         win_open <= 1'b0;
         win_cnt <= 9'h000;
      end else if (first_ok) begin
         win_open <= 1'b1;
         win_cnt <= 9'h000;
      end else if (second_ok | second_bad | win_exp | blocked) begin
         win_open <= 1'b0;
         win_cnt <= 9'h000;
      end else if (win_open) begin
         win_cnt <= win_cnt + 9'h001;
      end
   end

   // Control contents; config word only while the lock is open
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         reload <= `WDP_RELOAD_RST;
         lock <= 1'b0;
         cfg <= '{user_pw: `WDP_UPW_RST, slow_sel: 1'b0, cnt_dis: 1'b0};
      end else begin
         if (second_ok) begin
            reload <= i_hwdata[`WDP_C0_RELOAD];
            lock <= new_lock;
         end else if ((next_state == wdp_pkg::WDP_ST_RESET)
            | (next_state == wdp_pkg::WDP_ST_HALT)) begin
            lock <= 1'b0;
         end
         if (wr_c1 & ~lock & ~blocked) begin
            cfg.cnt_dis <= i_hwdata[`WDP_C1_DIS];
            cfg.slow_sel <= i_hwdata[`WDP_C1_FSEL];
            cfg.user_pw <= i_hwdata[`WDP_C1_UPW];
         end
      end
   end

   // Supervision state, counter and reset bookkeeping
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= wdp_pkg::WDP_ST_TIMEOUT;
         cnt <= `WDP_TIMEOUT_RELOAD;
         rst_cnt <= 8'h00;
         reset_seen <= 1'b0;
         err_acc <= 1'b0;
         err_ovf <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         rst_cnt <= (state == wdp_pkg::WDP_ST_RESET) ? rst_cnt + 8'h01 : 8'h00;
         // Power-on or a valid access clears the double reset memory
         if (next_state == wdp_pkg::WDP_ST_RESET) begin
            reset_seen <= 1'b1;
         end else if (second_ok) begin
            reset_seen <= 1'b0;
         end
         if (~blocked & acc_err) begin
            err_acc <= 1'b1;
         end
         if (~blocked & ovf) begin
            err_ovf <= 1'b1;
         end
      end
   end

   // Interrupt registers; software clears status by writing ones
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         irq_st <= 3'h0;
         irq_mask <= 3'h0;
         o_irq <= 1'b0;
      end else begin
         irq_st <= next_irq_st;
         if (wr_mask) begin
            irq_mask <= i_hwdata[`WDP_IRQ_W-1:0];
         end
         o_irq <= |(next_irq_st & (wr_mask ? i_hwdata[`WDP_IRQ_W-1:0] : irq_mask));
      end
   end

   // Outputs from flops, aligned with the state they report
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_nmi <= 1'b0;
         o_wd_reset <= 1'b0;
         o_init_done_lock <= 1'b0;
      end else begin
         o_nmi <= (next_state == wdp_pkg::WDP_ST_PREWARN);
         o_wd_reset <= (next_state == wdp_pkg::WDP_ST_RESET)
            | (next_state == wdp_pkg::WDP_ST_HALT);
         o_init_done_lock <= second_ok ? new_lock
            : (((next_state == wdp_pkg::WDP_ST_RESET)
            | (next_state == wdp_pkg::WDP_ST_HALT)) ? 1'b0 : lock);
      end
   end

endmodule : wdp_top
`default_nettype wire

// ---- wdp_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on bus timing and the error escalation
module wdp_top_props (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_init_done_lock,
   input wire logic o_nmi,
   input wire logic o_wd_reset
);
   logic take;
   logic [5:0] hi_cnt;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // Accepted address phase
   assign take = i_hsel && i_htrans[1] && i_hready;

   // Cycles the reset pulse has stood so far; wraps only in halt, which never falls
   always_ff @(posedge i_clk) begin
      hi_cnt <= o_wd_reset ? hi_cnt + 6'h1 : 6'h0;
   end

   a_one_wait_state: assert property (take |=> !o_hreadyout ##1 o_hreadyout)
      else $error("wait state not exactly one cycle");
   a_no_idle_wait: assert property (!take |=> o_hreadyout)
      else $error("wait state without a transfer");
   a_resp_okay: assert property (!o_hresp)
      else $error("error response seen");
   a_rdata_holds: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
      else $error("read data moved outside a read");
   a_nmi_before_reset: assert property ($rose(o_wd_reset) |-> $past(o_nmi))
      else $error("reset without prewarning");
   a_reset_pulse_len: assert property ($fell(o_wd_reset) |-> hi_cnt == 6'h10)
      else $error("reset pulse length wrong");
   a_lock_clears: assert property ($rose(o_wd_reset) |-> !o_init_done_lock)
      else $error("lock kept through reset");
   a_nmi_held: assert property ($rose(o_nmi) |-> o_nmi [*8])
      else $error("prewarning too short");
endmodule : wdp_top_props

bind wdp_top wdp_top_props wdp_top_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hready(i_hready), .o_hrdata(o_hrdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_init_done_lock(o_init_done_lock),
   .o_nmi(o_nmi), .o_wd_reset(o_wd_reset));

`default_nettype wire

// ---- wdp_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// CPU side of the register bus: single word transfers, prompt or slow
module wdp_cpu_model (
   input wire logic i_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   int gap = 0; // Idle cycles before each request, still inside the interval

   // Idle bus from time zero
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = 3'h2;
      o_hwdata = 32'h0;
   end

   // One word transfer; control word 0 writes come as two of these
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      repeat (gap) @(posedge i_clk);
      o_hsel <= 1'b1;
      o_haddr <= {24'h0, a};
      o_hwrite <= wr;
      o_htrans <= 2'h2;
      do @(posedge i_clk); while (!i_hready);
      o_hsel <= 1'b0;
      o_htrans <= 2'h0;
      o_hwdata <= d;
      do @(posedge i_clk); while (!i_hready);
      q = i_hrdata;
      o_hwdata <= ~d; // Released data must not look valid
   endtask : xfer
endmodule : wdp_cpu_model

`default_nettype wire

// ---- wdp_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdp_consts.svh"

module wdp_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hready, hresp, lock, nmi, wdr, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   int num_errors = 0;
   int n_compared = 0;
   int i;

   // 250 MHz system clock
   always #2 clk = ~clk;

   wdp_top wdp_top_i (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready),
      .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .o_init_done_lock(lock), .o_nmi(nmi), .o_wd_reset(wdr), .o_irq(irq));

   wdp_cpu_model wdp_cpu_model_i (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata),
      .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
      .o_hsize(hsize), .o_hwdata(hwdata));

   // Compare and tally
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wdp_cpu_model_i.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      wdp_cpu_model_i.xfer(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic stop_test();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   // Hang guard; the full run needs about 270 us
   initial begin
      #400000;
      num_errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("lock", {31'h0, lock}, 32'h0);
      rd(`WDP_ADDR_STAT);
      check("status", q, 32'h8);
      rd(`WDP_ADDR_CTRL1);
      check("ctrl1", q, 32'h0);
      rd(8'h18);
      check("unmapped", q, 32'h0);
      // Slow but valid service pair
      wdp_cpu_model_i.gap = 3;
      wr(`WDP_ADDR_CTRL0, 32'h0000_5000);
      rd(`WDP_ADDR_STAT);
      check("window", q, 32'h9);
      wr(`WDP_ADDR_CTRL0, 32'h1234_00a1);
      check("lock", {31'h0, lock}, 32'h1);
      rd(`WDP_ADDR_CNT);
      check("count", {24'h0, q[15:8]}, 32'h12);
      rd(`WDP_ADDR_STAT);
      check("status", q, 32'h12);
      wdp_cpu_model_i.gap = 0;
      // Interrupt raise, mask and clear
      rd(`WDP_ADDR_IRQ);
      check("irq flags", q, 32'h3);
      wr(`WDP_ADDR_MASK, 32'h1);
      check("irq", {31'h0, irq}, 32'h1);
      wr(`WDP_ADDR_IRQ, 32'h1);
      check("irq", {31'h0, irq}, 32'h0);
      // Configuration frozen while locked
      wr(`WDP_ADDR_CTRL1, 32'h3);
      rd(`WDP_ADDR_CTRL1);
      check("ctrl1", q, 32'h0);
      // Window left to lapse
      wr(`WDP_ADDR_CTRL0, 32'h0000_5000);
      repeat (300) @(posedge clk);
      rd(`WDP_ADDR_IRQ);
      check("irq flags", q, 32'h6);
      check("nmi", {31'h0, nmi}, 32'h0);
      // Bad guard on the second write escalates
      wr(`WDP_ADDR_CTRL0, 32'h0000_5000);
      wr(`WDP_ADDR_CTRL0, 32'h0000_0051);
      repeat (3) @(posedge clk);
      check("nmi", {31'h0, nmi}, 32'h1);
      rd(`WDP_ADDR_STAT);
      check("error state", {26'h0, q[8:3]}, 32'h24);
      for (i = 0; i < 70000 && !wdr; i++) @(posedge clk);
      check("reset", {31'h0, wdr}, 32'h1);
      check("prewarn time", {31'h0, i > 65000 && i <= 65536}, 32'h1);
      check("lock", {31'h0, lock}, 32'h0);
      for (i = 0; i < 40 && wdr; i++) @(posedge clk);
      rd(`WDP_ADDR_STAT);
      check("status", {25'h0, q[7:1]}, 32'h6);
      // User password 3 and counting off, then service into normal mode
      wr(`WDP_ADDR_CTRL1, 32'h31);
      rd(`WDP_ADDR_CTRL1);
      check("ctrl1", q, 32'h31);
      wr(`WDP_ADDR_CTRL0, 32'hfff0_5300);
      wr(`WDP_ADDR_CTRL0, 32'hfff0_00a1);
      rd(`WDP_ADDR_STAT);
      check("status", {25'h0, q[7:1]}, 32'h9);
      // Disabled counting holds the reload across several prescaler ticks
      repeat (600) @(posedge clk);
      rd(`WDP_ADDR_CNT);
      check("count", q, 32'hfff0);
      // Old password is now wrong; protection stays on with counting off
      wr(`WDP_ADDR_CTRL0, 32'h0000_5000);
      repeat (3) @(posedge clk);
      check("nmi", {31'h0, nmi}, 32'h1);
      stop_test();
   end
endmodule : wdp_top_tb

`default_nettype wire
